/* File: dv/ref_loop_model.sv */
// reference source, phase detector and lock pin capacitor model
`timescale 1ns/10ps
module ref_loop_model
  import holdover_pkg::*;
#(
  parameter int CHARGE = 4 // cycles of lock before the pin trips
)
(
  input wire logic clk_i, // 40 mhz clock
  input wire logic rst_i, // synchronous reset
  input wire logic run_i, // reference present
  input wire logic win_i, // next edges inside lock window
  input wire logic unl_i, // next edges beyond unlock window
  input wire logic dig_lock_i, // digital lock flag from the block
  output logic pfd_ref_edge_o, // one pulse every eight cycles
  output logic in_window_o, // qualifier of the pulse
  output logic unlock_o, // qualifier of the pulse
  output logic ref_one_ok_o, // reference one present
  output logic ref_two_ok_o, // reference two present
  output logic lock_comp_o // lock pin comparator
);
  logic [2:0] ph;
  logic [3:0] chg;
  // phase counter runs free so edges stop at once when the reference goes
  always_ff @(posedge clk_i) begin
    if (rst_i) ph <= 3'h0;
    else ph <= ph + 3'h1;
  end
  always_ff @(posedge clk_i) begin
    pfd_ref_edge_o <= !rst_i && run_i && ph == 3'h7;
  end
  // qualifiers toggle between pulses so stale values cannot pass
  assign in_window_o = pfd_ref_edge_o ? win_i : ph[0];
  assign unlock_o = pfd_ref_edge_o ? unl_i : ph[1];
  assign ref_one_ok_o = run_i;
  assign ref_two_ok_o = 1'b1;
  // current source charges the pin cap; any lock drop discharges it
  always_ff @(posedge clk_i) begin
    if (rst_i || !dig_lock_i) chg <= 4'h0;
    else if (chg != CHARGE[3:0]) chg <= chg + 4'h1;
  end
  assign lock_comp_o = chg == CHARGE[3:0];
endmodule // ref_loop_model

/* File: dv/tb_pll_holdover_control.sv */
// self-checking bench for the holdover controller
`timescale 1ns/10ps
`define CK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", nm, e, s); end end
module tb_pll_holdover_control
  import holdover_pkg::*;
;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, sync_n_i = 1;
  logic [11:0] adr_i = 12'h000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic ack_o, lock_comp_i, pfd_ref_edge_i, pfd_in_window_i, pfd_unlock_i;
  logic ref_one_ok_i, ref_two_ok_i, charge_pump_hiz_o, b_counter_reset_o;
  logic digital_lock_flag_o, current_source_lock_mode_o, lock_window_high_o, ref_sel_o;
  logic [5:0] lock_pin_mode_o;
  logic [1:0] ref_buf_en_o;
  logic [3:0] ignore_sync_o;
  logic run = 0, win = 0, unl = 0;
  logic [7:0] q;
  int n_fail = 0, checks_done = 0, n;
  localparam logic [11:0] LD = {IDX_LOCK_DETECT, 2'b00}, HO = {IDX_HOLDOVER, 2'b00};
  localparam logic [11:0] ST = {IDX_STATUS, 2'b00};
  // address, write value, expected read; row 7 is unmapped
  logic [11:0] ra [9] = '{12'h060, 12'h068, 12'h070, 12'h644, 12'h650, 12'h65c,
    12'h668, 12'h0fc, 12'h074};
  // reference control: auto switchover on, prefer reference one, both buffers on
  logic [7:0] rw [9] = '{8'h00, 8'h04, 8'h16, 8'h40, 8'h40, 8'h40, 8'h40, 8'hff, 8'h00};
  logic [7:0] rr [9] = '{8'h00, 8'h04, 8'h16, 8'h40, 8'h40, 8'h40, 8'h40, 8'h00, 8'h00};
  pll_holdover_control dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .sync_n_i, .lock_comp_i, .pfd_ref_edge_i, .pfd_in_window_i,
    .pfd_unlock_i, .ref_one_ok_i, .ref_two_ok_i, .charge_pump_hiz_o, .b_counter_reset_o,
    .digital_lock_flag_o, .current_source_lock_mode_o, .lock_pin_mode_o,
    .lock_window_high_o, .ref_buf_en_o, .ref_sel_o, .ignore_sync_o);
  ref_loop_model far (.clk_i, .rst_i, .run_i(run), .win_i(win), .unl_i(unl),
    .dig_lock_i(digital_lock_flag_o), .pfd_ref_edge_o(pfd_ref_edge_i),
    .in_window_o(pfd_in_window_i), .unlock_o(pfd_unlock_i), .ref_one_ok_o(ref_one_ok_i),
    .ref_two_ok_o(ref_two_ok_i), .lock_comp_o(lock_comp_i));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // one classic cycle; read data lands in q
  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    sel_i <= 4'h1;
    // no bound here: only the watchdog ends a missing acknowledge
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  // bounded wait for a level
  task automatic till(ref logic s, input logic v, input int lim);
    int k;
    k = 0;
    while (s !== v && k < lim) begin
      @(posedge clk_i);
      k++;
    end
    // a wait that runs out counts as a mismatch
    if (s !== v) begin
      n_fail++;
      $display("ERROR wait expected %h seen %h", v, s);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // watchdog, far above the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    close_out();
  end
  initial begin
    wt(20);
    rst_i <= 1'b0;
    wt(1);
    `CK("hiz", 1'b0, charge_pump_hiz_o)
    `CK("window", 1'b1, lock_window_high_o)
    `CK("refsel", 1'b0, ref_sel_o)
    for (int i = 0; i < 9; i++) begin
      wb(1'b1, ra[i], rw[i]); // lock detect bit3 stays clear
      wb(1'b0, ra[i], 8'h00);
      `CK("reg", rr[i], q)
    end
    `CK("csmode", 1'b1, current_source_lock_mode_o)
    `CK("pinmode", 6'h04, lock_pin_mode_o)
    `CK("bufen", 2'b11, ref_buf_en_o)
    `CK("ignsync", 4'hf, ignore_sync_o)
    wb(1'b1, LD, 8'h10);
    `CK("window", 1'b0, lock_window_high_o)
    $display("test registers done");
    // holdover disabled: a sync fall does nothing
    wb(1'b1, HO, 8'h02);
    sync_n_i <= 1'b0;
    wt(10);
    `CK("hiz", 1'b0, charge_pump_hiz_o)
    sync_n_i <= 1'b1;
    wt(4);
    // manual holdover: enter on fall, leave on edge after sync high
    wb(1'b1, HO, 8'h03);
    sync_n_i <= 1'b0;
    till(charge_pump_hiz_o, 1'b1, 6);
    `CK("hiz", 1'b1, charge_pump_hiz_o)
    run <= 1'b1;
    wt(30);
    `CK("hiz", 1'b1, charge_pump_hiz_o)
    run <= 1'b0;
    sync_n_i <= 1'b1;
    wt(30);
    `CK("hiz", 1'b1, charge_pump_hiz_o)
    run <= 1'b1;
    till(b_counter_reset_o, 1'b1, 20);
    `CK("breset", 1'b1, b_counter_reset_o)
    `CK("hiz", 1'b0, charge_pump_hiz_o)
    $display("test manual done");
    // automatic mode, five in-window edges to lock
    wb(1'b1, LD, 8'h00);
    wb(1'b1, HO, 8'h09);
    n = 0;
    win <= 1'b1;
    for (int k = 0; k < 200 && digital_lock_flag_o !== 1'b1; k++) begin
      @(posedge clk_i);
      if (pfd_ref_edge_i === 1'b1 && pfd_in_window_i === 1'b1 &&
          digital_lock_flag_o !== 1'b1) n++;
    end
    `CK("edges", 32'd5, n)
    till(lock_comp_i, 1'b1, 20);
    `CK("hiz", 1'b0, charge_pump_hiz_o)
    unl <= 1'b1;
    till(digital_lock_flag_o, 1'b0, 20);
    `CK("lock", 1'b0, digital_lock_flag_o)
    unl <= 1'b0;
    run <= 1'b0;
    till(charge_pump_hiz_o, 1'b1, 10);
    `CK("hiz", 1'b1, charge_pump_hiz_o)
    wt(40);
    `CK("hiz", 1'b1, charge_pump_hiz_o)
    `CK("refsel", 1'b1, ref_sel_o)
    run <= 1'b1;
    till(b_counter_reset_o, 1'b1, 20);
    `CK("hiz", 1'b0, charge_pump_hiz_o)
    `CK("refsel", 1'b0, ref_sel_o)
    wt(10);
    wb(1'b0, ST, 8'h00);
    `CK("state", 2'b10, q[1:0])
    `CK("hiz", 1'b0, charge_pump_hiz_o)
    $display("test automatic done");
    // comparator off: the lock input reads high, no holdover
    till(lock_comp_i, 1'b1, 100);
    wb(1'b1, HO, 8'h01);
    unl <= 1'b1;
    till(lock_comp_i, 1'b0, 30);
    unl <= 1'b0;
    wt(20);
    `CK("hiz", 1'b0, charge_pump_hiz_o)
    $display("test comparator done");
    // reset in mid-run clears lock, state and registers
    till(digital_lock_flag_o, 1'b1, 80);
    rst_i <= 1'b1;
    wt(2);
    rst_i <= 1'b0;
    wt(1);
    `CK("hiz", 1'b0, charge_pump_hiz_o)
    `CK("lock", 1'b0, digital_lock_flag_o)
    wb(1'b0, HO, 8'h00);
    `CK("holdover", 8'h00, q)
    $display("test reset done");
    close_out();
  end
endmodule // tb_pll_holdover_control

/* File: hdl/holdover_pkg.sv */
// constants shared by the pll holdover controller
package holdover_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_LOCK_DETECT = 10'h018;
  localparam logic [9:0] IDX_LOCK_PIN = 10'h01a;
  localparam logic [9:0] IDX_REF_SELECT = 10'h01c;
  localparam logic [9:0] IDX_HOLDOVER = 10'h01d;
  localparam logic [9:0] IDX_STATUS = 10'h020;
  localparam logic [9:0] IDX_DIV0 = 10'h191;
  localparam int DIV_STRIDE = 3;
  localparam int NUM_DIV = 4;
  // field positions
  localparam int LD_CNT_LSB = 5;
  localparam int LD_WINDOW_BIT = 4;
  localparam int LD_DISABLE_BIT = 3;
  localparam int REF_AUTO_BIT = 4;
  localparam int REF_PREFER_BIT = 3;
  localparam int REF_BUF_LSB = 1;
  localparam int HO_COMP_BIT = 3;
  localparam int HO_EXT_BIT = 1;
  localparam int HO_EN_BIT = 0;
  localparam int IGNORE_SYNC_BIT = 6;
  localparam logic [5:0] LOCK_PIN_CURRENT_SRC = 6'h04;
  // reset values
  localparam logic [7:0] RST_LOCK_DETECT = 8'h00;
  localparam logic [7:0] RST_LOCK_PIN = 8'h00;
  localparam logic [7:0] RST_REF_SELECT = 8'h00;
  localparam logic [7:0] RST_HOLDOVER = 8'h00;
  localparam logic [7:0] RST_DIV = 8'h00;
  // consecutive in-window cycles per lock counter code
  localparam logic [7:0] LOCK_CNT_0 = 8'h05;
  localparam logic [7:0] LOCK_CNT_1 = 8'h10;
  localparam logic [7:0] LOCK_CNT_2 = 8'h40;
  localparam logic [7:0] LOCK_CNT_3 = 8'hff;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_REARM = 2'b10
  } hold_state_t;
endpackage

/* File: hdl/pll_holdover_control.sv */
// pll charge pump holdover controller with wishbone register slave
// Notes on behaviour
// - while holding over, the charge pump output is high impedance
// - the holdover enable bit gates both manual and automatic holdover
// - manual mode: a sync falling edge enters holdover at once
// - manual exit only at the next reference phase detector edge after sync high
// - leaving holdover resets the feedback b counter, never the prescaler
// - each channel divider has an ignore-sync bit 6; software sets it
// - automatic mode enters holdover when the lock input goes low
// - lock input is the pin comparator, or constant high when comparator off
// - automatic holdover persists while no reference edge reaches the detector
// - after exit, no re-entry until the lock input has gone high
// - holdover follows the selected reference; switchover loss ends at next edge
// - two-bit lock counter sets in-window cycles for lock; 00b means five
// - lock pin field 000100b selects current source lock mode
// - external holdover bit clear selects automatic holdover
// - reference control: auto switchover, preferred reference, buffer enables
// - lock window bit clear selects the high range window
// - lock after programmed in-window count; drop on one unlock-threshold cycle
//
// Chosen here: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
module pll_holdover_control
  import holdover_pkg::*;
(
  input wire logic clk_i, // 40 mhz clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic cyc_i, // wishbone cycle
  input wire logic stb_i, // wishbone strobe
  input wire logic we_i, // wishbone write
  input wire logic [11:0] adr_i, // wishbone byte address
  input wire logic [3:0] sel_i, // wishbone byte selects
  input wire logic [31:0] dat_i, // wishbone write data
  output logic [31:0] dat_o, // wishbone read data
  output logic ack_o, // wishbone acknowledge
  input wire logic sync_n_i, // sync pin, active low
  input wire logic lock_comp_i, // lock indicator pin comparator output
  input wire logic pfd_ref_edge_i, // pulse: reference phase detector edge
  input wire logic pfd_in_window_i, // edge phase error inside lock window
  input wire logic pfd_unlock_i, // edge phase error beyond unlock window
  input wire logic ref_one_ok_i, // reference one present
  input wire logic ref_two_ok_i, // reference two present
  output logic charge_pump_hiz_o, // charge pump high impedance
  output logic b_counter_reset_o, // one-cycle b counter reset
  output logic digital_lock_flag_o, // digital lock detector output
  output logic current_source_lock_mode_o, // lock pin in current source mode
  output logic [5:0] lock_pin_mode_o, // lock pin control field
  output logic lock_window_high_o, // high range lock window chosen
  output logic [1:0] ref_buf_en_o, // reference input buffer enables
  output logic ref_sel_o, // selected reference, 1 = reference two
  output logic [3:0] ignore_sync_o // per channel divider ignore-sync
);
  logic [7:0] lock_detect;
  logic [7:0] lock_pin;
  logic [7:0] ref_select;
  logic [7:0] holdover;
  logic [7:0] div_ctrl [NUM_DIV];
  logic [2:0] sync_pipe;
  logic [1:0] lock_pipe;
  logic [7:0] lock_cnt;
  logic dlock;
  logic b_reset;
  hold_state_t state;
  hold_state_t next_state;
  logic [9:0] idx;
  logic req;
  logic wr;
  logic hold_en;
  logic ext_mode;
  logic comp_en;
  logic lock_in;
  logic sync_fall;
  logic release_ok;
  logic [7:0] lock_target;

  // decode a lock counter code into its in-window cycle count
  function automatic logic [7:0] lock_count(input logic [1:0] code);
    case (code)
      2'b00: lock_count = LOCK_CNT_0;
      2'b01: lock_count = LOCK_CNT_1;
      2'b10: lock_count = LOCK_CNT_2;
      default: lock_count = LOCK_CNT_3;
    endcase
  endfunction

  // register index decode
  assign idx = adr_i[11:2];
  assign req = cyc_i & stb_i & ~ack_o;
  assign wr = req & we_i & sel_i[0];

  // ack one cycle after the strobe, then drop for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // configuration registers; only byte lane 0 carries data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_detect <= RST_LOCK_DETECT;
      lock_pin <= RST_LOCK_PIN;
      ref_select <= RST_REF_SELECT;
      holdover <= RST_HOLDOVER;
    end else if (wr) begin
      case (idx)
        IDX_LOCK_DETECT: lock_detect <= dat_i[7:0];
        IDX_LOCK_PIN: lock_pin <= dat_i[7:0];
        IDX_REF_SELECT: ref_select <= dat_i[7:0];
        IDX_HOLDOVER: holdover <= dat_i[7:0];
        default: ;
      endcase
    end
  end

  // channel divider control, bit 6 ignores the sync pin
  generate
    for (genvar g = 0; g < NUM_DIV; g++) begin : g_div
      localparam logic [9:0] DIV_IDX = IDX_DIV0 + 10'(g * DIV_STRIDE);
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          div_ctrl[g] <= RST_DIV;
        end else if (wr && idx == DIV_IDX) begin
          div_ctrl[g] <= dat_i[7:0];
        end
      end
      assign ignore_sync_o[g] = div_ctrl[g][IGNORE_SYNC_BIT];
    end
  endgenerate

  // read mux; unmapped addresses read as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (req) begin
      dat_o <= 32'h0000_0000;
      case (idx)
        IDX_LOCK_DETECT: dat_o[7:0] <= lock_detect;
        IDX_LOCK_PIN: dat_o[7:0] <= lock_pin;
        IDX_REF_SELECT: dat_o[7:0] <= ref_select;
        IDX_HOLDOVER: dat_o[7:0] <= holdover;
        IDX_STATUS: dat_o[7:0] <= {3'b000, ref_sel_o, lock_in, dlock, state};
        default: begin
          for (int k = 0; k < NUM_DIV; k++) begin
            if (idx == IDX_DIV0 + 10'(k * DIV_STRIDE)) begin
              dat_o[7:0] <= div_ctrl[k];
            end
          end
        end
      endcase
    end
  end

  // two-flop synchronisers; third sync stage only feeds edge detect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_pipe <= 3'b111;
      lock_pipe <= 2'b00;
    end else begin
      sync_pipe <= {sync_pipe[1:0], sync_n_i};
      lock_pipe <= {lock_pipe[0], lock_comp_i};
    end
  end

  assign sync_fall = sync_pipe[2] & ~sync_pipe[1];
  assign hold_en = holdover[HO_EN_BIT];
  assign ext_mode = holdover[HO_EXT_BIT];
  assign comp_en = holdover[HO_COMP_BIT];
  assign lock_in = comp_en ? lock_pipe[1] : 1'b1;

  // digital lock detector; counts in-window reference edges
  assign lock_target = lock_count(lock_detect[LD_CNT_LSB +: 2]);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_cnt <= 8'h00;
      dlock <= 1'b0;
    end else if (lock_detect[LD_DISABLE_BIT]) begin
      lock_cnt <= 8'h00;
      dlock <= 1'b0;
    end else if (pfd_ref_edge_i) begin
      if (pfd_unlock_i) begin
        lock_cnt <= 8'h00;
        dlock <= 1'b0;
      end else if (!pfd_in_window_i) begin
        lock_cnt <= 8'h00; // consecutive run broken, lock kept
      end else if (lock_cnt + 8'h01 >= lock_target) begin
        lock_cnt <= lock_target;
        dlock <= 1'b1;
      end else begin
        lock_cnt <= lock_cnt + 8'h01;
      end
    end
  end

  // manual exit waits for sync high; both exit only on a reference edge
  assign release_ok = pfd_ref_edge_i & (~ext_mode | sync_pipe[1]);

  // holdover state machine
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (hold_en && ext_mode && sync_fall) begin
          next_state = ST_HOLD;
        end else if (hold_en && !ext_mode && !lock_in) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!hold_en) begin
          next_state = ST_IDLE;
        end else if (release_ok) begin
          next_state = ext_mode ? ST_IDLE : ST_REARM;
        end
      end
      ST_REARM: begin
        if (!hold_en || ext_mode || lock_in) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // b counter reset lands on the same edge the charge pump leaves hiz
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      b_reset <= 1'b0;
    end else begin
      b_reset <= (state == ST_HOLD) && hold_en && release_ok;
    end
  end

  assign charge_pump_hiz_o = (state == ST_HOLD);
  assign b_counter_reset_o = b_reset;
  assign digital_lock_flag_o = dlock;
  assign lock_pin_mode_o = lock_pin[5:0];
  assign current_source_lock_mode_o = (lock_pin[5:0] == LOCK_PIN_CURRENT_SRC);
  assign lock_window_high_o = ~lock_detect[LD_WINDOW_BIT];
  assign ref_buf_en_o = ref_select[REF_BUF_LSB +: 2];

  // reference choice: preferred one unless auto switchover finds it absent
  always_comb begin
    ref_sel_o = ref_select[REF_PREFER_BIT];
    if (ref_select[REF_AUTO_BIT]) begin
      if (ref_select[REF_PREFER_BIT] ? !ref_two_ok_i : !ref_one_ok_i) begin
        ref_sel_o = ~ref_select[REF_PREFER_BIT];
      end
    end
  end

  // checks
  sequence s_holding;
    charge_pump_hiz_o && hold_en && release_ok;
  endsequence
  sequence s_released;
    !charge_pump_hiz_o && b_counter_reset_o ##1 !b_counter_reset_o;
  endsequence

  property p_enable_gates;
    @(posedge clk_i) disable iff (rst_i) !hold_en |=> !charge_pump_hiz_o;
  endproperty
  a_enable_gates: assert property (p_enable_gates)
    else $error("holdover active while disabled");

  property p_manual_enter;
    @(posedge clk_i) disable iff (rst_i)
      state == ST_IDLE && hold_en && ext_mode && sync_fall |=> charge_pump_hiz_o;
  endproperty
  a_manual_enter: assert property (p_manual_enter)
    else $error("sync fall did not enter holdover");

  property p_wait_edge;
    @(posedge clk_i) disable iff (rst_i)
      charge_pump_hiz_o && hold_en && !pfd_ref_edge_i |=> charge_pump_hiz_o;
  endproperty
  a_wait_edge: assert property (p_wait_edge)
    else $error("holdover left without reference edge");

  property p_b_reset;
    @(posedge clk_i) disable iff (rst_i) s_holding |=> s_released;
  endproperty
  a_b_reset: assert property (p_b_reset)
    else $error("b counter reset not aligned with exit");

  property p_auto_enter;
    @(posedge clk_i) disable iff (rst_i)
      state == ST_IDLE && hold_en && !ext_mode && comp_en && !lock_pipe[1]
      |=> charge_pump_hiz_o;
  endproperty
  a_auto_enter: assert property (p_auto_enter)
    else $error("lock loss did not enter holdover");

  property p_comp_off;
    @(posedge clk_i) disable iff (rst_i)
      state == ST_IDLE && !ext_mode && !comp_en ##1 !ext_mode && !comp_en
      |-> !charge_pump_hiz_o;
  endproperty
  a_comp_off: assert property (p_comp_off)
    else $error("holdover entered with comparator off");

  property p_rearm;
    @(posedge clk_i) disable iff (rst_i)
      state == ST_REARM && !lock_in |=> !charge_pump_hiz_o;
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("holdover re-entered before lock returned");

  property p_lock_drop;
    @(posedge clk_i) disable iff (rst_i)
      pfd_ref_edge_i && pfd_unlock_i |=> !digital_lock_flag_o;
  endproperty
  a_lock_drop: assert property (p_lock_drop)
    else $error("digital lock kept after unlock cycle");

  property p_sync_delay;
    @(posedge clk_i) disable iff (rst_i)
      $fell(sync_n_i) ##1 !sync_n_i |=> !sync_pipe[1];
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("sync pin not synchronised in two stages");
endmodule // pll_holdover_control
